/* include/mapg_regs.vh */
`ifndef MAPG_REGS_VH
`define MAPG_REGS_VH
// ****************************************
// timing defaults
// ****************************************
`define MAPG_CNT_W        16
`define MAPG_HALF_RST     16'h0000
`define MAPG_CNT_ONE      16'h0001
`define MAPG_SYNC_IDLE    6'h0a
`define MAPG_HALF_DEF     16'h0010
`define MAPG_SYNC_RST     3'h0
`endif

/* hdl/mapg_pulse_gen.v */
`timescale 1ns/1ps
// Operation
// - astable mode runs while astable_enable_high is high or astable_enable_low_n is low.
// - in astable mode q is a 50 percent square wave and q_n is always its inverse.
// - osc_out toggles at twice the q frequency, duty cycle not guaranteed.
// - the two astable enables start and stop oscillation, giving a gated oscillator.
// - one-shot mode applies with astable_enable_high low and astable_enable_low_n high.
// - a one-shot starts on trigger_rise rising with trigger_fall_n low, or trigger_fall_n falling with trigger_rise high.
// - retrigger_in rising together with trigger_rise, trigger_fall_n low, restarts the pulse.
// - the timing setting fixes pulse width in one-shot and frequency in astable mode.
// - overriding_reset high forces q low and q_n high over every other input.
`include "mapg_regs.vh"
module mapg_pulse_gen (
    input  wire                    clk,
    input  wire                    reset,
    input  wire                    astable_enable_high,
    input  wire                    astable_enable_low_n,
    input  wire                    trigger_rise,
    input  wire                    trigger_fall_n,
    input  wire                    retrigger_in,
    input  wire                    overriding_reset,
    input  wire [`MAPG_CNT_W-1:0]  half_period_cycles,
    output wire                    q,
    output wire                    q_n,
    output wire                    osc_out
);

    // ****************************************
    // local constants
    // ****************************************
    localparam                   NUM_PINS   = 6;
    localparam [NUM_PINS-1:0]    PIN_IDLE   = `MAPG_SYNC_IDLE;
    localparam                   PIN_EN_HI  = 0;
    localparam                   PIN_EN_LO  = 1;
    localparam                   PIN_TRIG_R = 2;
    localparam                   PIN_TRIG_F = 3;
    localparam                   PIN_RETRIG = 4;
    localparam                   PIN_MRST   = 5;

    localparam [1:0]             ST_IDLE    = 2'b00;
    localparam [1:0]             ST_SHOT    = 2'b01;
    localparam [1:0]             ST_ASTB    = 2'b10;

    localparam [`MAPG_CNT_W-1:0] CNT_ZERO   = `MAPG_HALF_RST;
    localparam [`MAPG_CNT_W-1:0] CNT_ONE    = `MAPG_CNT_ONE;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // master reset included; a pulse shorter than the filter only gates outputs
    wire [NUM_PINS-1:0] pins_in;
    reg  [NUM_PINS-1:0] s1_ff;
    reg  [NUM_PINS-1:0] s2_ff;
    reg  [NUM_PINS-1:0] s3_ff;
    reg  [NUM_PINS-1:0] filt_ff;
    reg  [NUM_PINS-1:0] prev_ff;

    assign pins_in = {overriding_reset,
                      retrigger_in,
                      trigger_fall_n,
                      trigger_rise,
                      astable_enable_low_n,
                      astable_enable_high};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (reset) begin
                    // idle pin levels, so no false edge follows reset
                    s1_ff[gi]   <= PIN_IDLE[gi];
                    s2_ff[gi]   <= PIN_IDLE[gi];
                    s3_ff[gi]   <= PIN_IDLE[gi];
                    filt_ff[gi] <= PIN_IDLE[gi];
                    prev_ff[gi] <= PIN_IDLE[gi];
                end else begin
                    s1_ff[gi]   <= pins_in[gi];
                    s2_ff[gi]   <= s1_ff[gi];
                    s3_ff[gi]   <= s2_ff[gi];
                    // change counts only when stages two and three agree
                    if (s2_ff[gi] == s3_ff[gi])
                        filt_ff[gi] <= s3_ff[gi];
                    prev_ff[gi] <= filt_ff[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // mode and trigger decode
    // ****************************************
    wire mr_now    = filt_ff[PIN_MRST];
    wire astable   = filt_ff[PIN_EN_HI] | ~filt_ff[PIN_EN_LO];
    wire monostbl  = ~astable;
    wire rise_edge = filt_ff[PIN_TRIG_R] & ~prev_ff[PIN_TRIG_R];
    wire fall_edge = ~filt_ff[PIN_TRIG_F] & prev_ff[PIN_TRIG_F];
    wire rt_edge   = filt_ff[PIN_RETRIG] & ~prev_ff[PIN_RETRIG];
    wire trig      = (rise_edge & ~filt_ff[PIN_TRIG_F]) |
                     (fall_edge & filt_ff[PIN_TRIG_R]);
    wire retrig    = rt_edge & rise_edge & ~filt_ff[PIN_TRIG_F];

    // ****************************************
    // timing core
    // ****************************************
    // zero count treated as one so the output never stalls
    wire [`MAPG_CNT_W-1:0] half_len = (half_period_cycles == CNT_ZERO) ?
                                      CNT_ONE : half_period_cycles;
    wire [`MAPG_CNT_W-1:0] quarter  = {1'b0, half_len[`MAPG_CNT_W-1:1]};
    wire [`MAPG_CNT_W-1:0] cnt_inc  = cnt_ff + CNT_ONE;
    wire                   half_done    = (cnt_inc >= half_len);
    wire                   quarter_done = (cnt_inc >= quarter);

    reg  [`MAPG_CNT_W-1:0] cnt_ff;
    reg  [`MAPG_CNT_W-1:0] nxt_cnt;
    reg                    q_ff;
    reg                    nxt_q;
    reg                    osc_ff;
    reg                    nxt_osc;
    reg  [1:0]             state_ff;
    reg  [1:0]             nxt_state;

    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_q     = q_ff;
        nxt_osc   = osc_ff;
        if (mr_now) begin
            nxt_state = ST_IDLE;
            nxt_cnt   = CNT_ZERO;
            nxt_q     = 1'b0;
            nxt_osc   = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_cnt = CNT_ZERO;
                    nxt_osc = 1'b0;
                    if (astable) begin
                        nxt_state = ST_ASTB;
                    end else if (monostbl & (retrig | trig)) begin
                        nxt_q     = 1'b1;
                        nxt_state = ST_SHOT;
                    end
                end
                ST_SHOT: begin
                    nxt_osc = 1'b0;
                    if (astable) begin
                        nxt_state = ST_ASTB;
                        nxt_cnt   = CNT_ZERO;
                    end else if (retrig) begin
                        // plain trigger edges fall through: no extension
                        nxt_cnt   = CNT_ZERO;
                    end else if (half_done) begin
                        nxt_cnt   = CNT_ZERO;
                        nxt_q     = 1'b0;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_cnt   = cnt_inc;
                    end
                end
                ST_ASTB: begin
                    if (!astable) begin
                        // a high output left behind finishes as a one-shot
                        nxt_osc   = 1'b0;
                        nxt_cnt   = CNT_ZERO;
                        nxt_state = q_ff ? ST_SHOT : ST_IDLE;
                    end else if (half_done) begin
                        nxt_cnt   = CNT_ZERO;
                        nxt_q     = ~q_ff;
                        nxt_osc   = 1'b1;
                    end else begin
                        nxt_cnt   = cnt_inc;
                        if (quarter_done) begin
                            nxt_osc = 1'b0;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = CNT_ZERO;
                    nxt_q     = 1'b0;
                    nxt_osc   = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            cnt_ff <= CNT_ZERO;
            q_ff   <= 1'b0;
            osc_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            q_ff   <= nxt_q;
            osc_ff <= nxt_osc;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // raw pin gating keeps the override immediate, not five clocks late
    assign q       = q_ff & ~overriding_reset;
    assign q_n     = ~q;
    assign osc_out = osc_ff & ~overriding_reset;
endmodule // mapg_pulse_gen

/* tb/mapg_pulse_gen_asserts.sv */
`timescale 1ns/1ps
// ****
// checker
// ****
module mapg_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        astable_enable_high,
    input wire logic        astable_enable_low_n,
    input wire logic        trigger_rise,
    input wire logic        trigger_fall_n,
    input wire logic        overriding_reset,
    input wire logic [15:0] half_period_cycles,
    input wire logic        q,
    input wire logic        q_n,
    input wire logic        osc_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ast; (astable_enable_high || !astable_enable_low_n)[*8]; endsequence
    sequence s_mono; (!astable_enable_high && astable_enable_low_n)[*8]; endsequence
    property p_inv; q_n == !q; endproperty
    a_inv: assert property (p_inv) else $error("q_n not inverse");
    property p_mr; overriding_reset |-> !q && q_n; endproperty
    a_mr: assert property (p_mr) else $error("reset ignored");
    property p_tog;
        s_ast ##0 (half_period_cycles <= 16'h000c) |->
            ##[1:12] ($changed(q) || !(astable_enable_high || !astable_enable_low_n));
    endproperty
    a_tog: assert property (p_tog) else $error("no toggle");
    property p_osc; s_ast ##0 $changed(q) |-> ##[0:3] osc_out ##[1:9] !osc_out; endproperty
    a_osc: assert property (p_osc) else $error("osc missing");
    property p_mono; s_mono |-> !osc_out; endproperty
    a_mono: assert property (p_mono) else $error("osc in one-shot");
    property p_rise; s_mono ##0 ($rose(trigger_rise) && !trigger_fall_n && !q) |-> ##[3:7] q;
    endproperty
    a_rise: assert property (p_rise) else $error("no start");
    property p_fall; s_mono ##0 ($fell(trigger_fall_n) && trigger_rise && !q) |-> ##[3:7] q;
    endproperty
    a_fall: assert property (p_fall) else $error("no start");
    property p_hold; $rose(q) && half_period_cycles >= 16'h0008 |-> (q || overriding_reset)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("short pulse");
endmodule // mapg_chk
bind mapg_pulse_gen mapg_chk mapg_chk_inst (.*);

/* tb/mapg_pulse_gen_tb_top.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module mapg_pulse_gen_tb_top;
    logic        clk, reset, astable_enable_high, astable_enable_low_n, trigger_rise, v;
    logic        trigger_fall_n, retrigger_in, overriding_reset, q, q_n, osc_out;
    logic [15:0] half_period_cycles = 16'h000c;
    int          bad_count, num_checks, n, k, i, m, osc_n;
    mapg_pulse_gen mapg_pulse_gen_inst (.*);
    always @(posedge osc_out) osc_n++;
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        report_and_stop;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %0d got %0d", s, e, g);
        end
    endtask
    task cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task lvl;
        v = q;
        for (n = 0; q === v && n < 99; n++) @(negedge clk);
    endtask
    // modes 0 rise, 1 fall, 2 retrigger, 3 plain re-rise, 4 reset mid pulse
    task t_shot(input int md);
        if (md == 1) trigger_rise = 1;
        else trigger_fall_n = 0;
        cyc(3);
        if (md == 1) trigger_fall_n = 0;
        else trigger_rise = 1;
        for (i = 0; i < 20 && q !== 1'b1; i++) @(negedge clk);
        if (md > 1) trigger_rise = 0;
        cyc(2);
        if (md > 1) begin
            trigger_rise = md < 4;
            retrigger_in = md == 2;
            overriding_reset = md == 4;
        end
        lvl;
        if (md == 4) chk("reset", 16'h0001, {q, q_n});
        else chk("width", 1, md == 2 ? n > 10 : n == 10);
        {trigger_rise, retrigger_in} = 0;
        trigger_fall_n = 1;
        cyc(14);
        overriding_reset = 0;
        cyc(20);
    endtask
    task t_ast(input logic hi, input logic lo_n);
        astable_enable_high = hi;
        astable_enable_low_n = lo_n;
        cyc(8);
        lvl;
        k = osc_n;
        lvl;
        chk("half", 12, n);
        lvl;
        chk("half", 12, n);
        chk("osc", 2, osc_n - k);
        astable_enable_high = 0;
        astable_enable_low_n = 1;
        cyc(40);
        lvl;
        chk("stop", 99, n);
        chk("stop level", 16'h0001, {q, q_n});
    endtask
    initial begin
        {astable_enable_high, trigger_rise, retrigger_in, overriding_reset, osc_n} = 0;
        {astable_enable_low_n, trigger_fall_n, reset} = 3'h7;
        cyc(3);
        reset = 0;
        cyc(2);
        chk("idle", 16'h0001, {q, q_n});
        for (m = 0; m < 5; m++) t_shot(m);
        t_ast(1, 1);
        t_ast(0, 0);
        report_and_stop;
    end
endmodule // mapg_pulse_gen_tb_top
